// File: status_map.svh
// Purpose: offsets, field positions and reset values of the status reporting block
// Assumes: included by the design modules, the assertions and the bench; the package does not include it
// Notes: the register port uses a small local address space, one entry per register
//
// Summary of operation
// - error-free decode with no enabled quality event reports bit 3 zero
// - status byte bit 4 while output data waits
// - two 16-bit condition registers, one 8-bit standard event register
// - condition rising edge sets event bit
// - reading event register clears it; events arriving that cycle survive
// - enable masks gate events into summary bits
// - enabled quality event asserts status bit 3
// - masked OR except bit 6 into bit 6
// - bit 6 set drives service request line
// - nonempty error queue sets status bit 3
// - normal-run unused bits always read zero
// - bit 5 waiting trigger, held while external trigger input low
// - bit 6 while transient function enabled
// - bit 8 voltage mode, bit 10 current mode
// - bits 9 and 12 event path only
// - bit 11 sample done, bit 14 list running
// - quality bit 0 current, bit 1 voltage mode
// - quality bit 3 thermal, bit 6 slave fault
// - bits 12,13 protection; with external reference either protection sets both
// - quality bit 14 while sinking load energy
// - quality unused bits always read zero
`ifndef STATUS_MAP_SVH
`define STATUS_MAP_SVH

`define ADDR_RUN_COND      4'h0
`define ADDR_RUN_EVENT     4'h1
`define ADDR_RUN_ENABLE    4'h2
`define ADDR_QUAL_COND     4'h3
`define ADDR_QUAL_EVENT    4'h4
`define ADDR_QUAL_ENABLE   4'h5
`define ADDR_STD_EVENT     4'h6
`define ADDR_STD_ENABLE    4'h7
`define ADDR_SRQ_STATUS    4'h8
`define ADDR_SRQ_ENABLE    4'h9

`define RUN_WTG_BIT        5
`define RUN_TRANS_ARM_BIT  6
`define RUN_CV_BIT         8
`define RUN_TRANS_DONE_BIT 9
`define RUN_CC_BIT         10
`define RUN_SAMPLE_BIT     11
`define RUN_LIST_DONE_BIT  12
`define RUN_LIST_RUN_BIT   14
`define RUN_COND_MASK      16'h5D60

`define QUAL_CUR_BIT       0
`define QUAL_VOLT_BIT      1
`define QUAL_THERM_BIT     3
`define QUAL_SLAVE_BIT     6
`define QUAL_VPROT_BIT     12
`define QUAL_CPROT_BIT     13
`define QUAL_SINK_BIT      14
`define QUAL_COND_MASK     16'h704B

`define STB_ERRQ_BIT       2
`define STB_QUAL_BIT       3
`define STB_MAV_BIT        4
`define STB_STD_BIT        5
`define STB_RQS_BIT        6
`define STB_RUN_BIT        7

`define RESET_WORD         16'h0000
`define RESET_BYTE         8'h00

`endif

// File: status_pkg.sv
// Purpose: shared types of the status reporting block
// Assumes: nothing
// Notes: constants live in status_map.svh
package status_pkg;
  typedef logic [15:0] word_t;
  typedef logic [7:0]  byte_t;
  typedef logic [3:0]  reg_addr_t;
endpackage : status_pkg

// File: event_latch.sv
// Purpose: edge-detecting event register with clear on read
// Assumes: cond comes from logic on mclk
// Notes: one instance per event register
`timescale 1ns/1ps
`include "status_map.svh"
module event_latch
  import status_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] cond,
  input  wire logic [W-1:0] pulse,
  input  wire logic         rd_clear,
  output logic      [W-1:0] events
);
  logic [W-1:0] cond_prev;
  logic [W-1:0] rise;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cond_prev <= '0;
    end else begin
      cond_prev <= cond;
    end
  end

  assign rise = (cond & ~cond_prev) | pulse;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      events <= '0;
    end else if (rd_clear) begin
      events <= rise;
    end else begin
      events <= events | rise;
    end
  end
endmodule : event_latch

// File: status_reporting.sv
// Purpose: condition, event and enable registers feeding the status byte and service request
// Assumes: status inputs are raw pins or foreign logic, synchronised here; reads from mclk logic
// Notes: standard event bit meanings belong to the parser; only its byte is latched here
`timescale 1ns/1ps
`include "status_map.svh"
module status_reporting
  import status_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      sys_rst,
  input  wire logic      trig_enabled,
  input  wire logic      trig_external,
  input  wire logic      trig_in,
  input  wire logic      transient_armed,
  input  wire logic      transient_done,
  input  wire logic      volt_mode,
  input  wire logic      curr_mode,
  input  wire logic      sample_done,
  input  wire logic      list_done,
  input  wire logic      list_running,
  input  wire logic      thermal_fault,
  input  wire logic      slave_fault,
  input  wire logic      volt_protect,
  input  wire logic      curr_protect,
  input  wire logic      ext_ref_enabled,
  input  wire logic      sinking,
  input  wire logic      error_queue_nonempty,
  input  wire logic      output_data_waiting,
  input  wire logic [7:0] std_event_set,
  input  wire reg_addr_t reg_addr,
  input  wire logic      reg_rd,
  input  wire logic      reg_wr,
  input  wire logic [15:0] reg_wdata,
  output logic     [15:0] reg_rdata,
  output logic           reg_rvalid,
  output logic      [7:0] status_byte,
  output logic           srq
);
  localparam int NSYNC = 18;

  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] raw;

  assign raw = {trig_enabled, trig_external, trig_in, transient_armed, transient_done,
                volt_mode, curr_mode, sample_done, list_done, list_running,
                thermal_fault, slave_fault, volt_protect, curr_protect,
                ext_ref_enabled, sinking, error_queue_nonempty, output_data_waiting};

  // two-stage synchronisers, first stage read only by the second
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
    end
  end

  logic s_trig_en, s_trig_ext, s_trig_in, s_trans_arm, s_trans_done, s_cv, s_cc;
  logic s_sample, s_list_done, s_list_run, s_therm, s_slave, s_vprot, s_cprot;
  logic s_extref, s_sink, s_errq, s_mav;

  assign {s_trig_en, s_trig_ext, s_trig_in, s_trans_arm, s_trans_done, s_cv, s_cc,
          s_sample, s_list_done, s_list_run, s_therm, s_slave, s_vprot, s_cprot,
          s_extref, s_sink, s_errq, s_mav} = sync_b;

  // waiting-for-trigger holds through a low external trigger input
  logic waiting_trigger_flag;
  logic trig_held;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      trig_held <= 1'b0;
    end else if (s_trig_ext && !s_trig_in && (s_trig_en || trig_held)) begin
      trig_held <= 1'b1;
    end else if (s_trig_in || !s_trig_ext) begin
      trig_held <= 1'b0;
    end
  end

  assign waiting_trigger_flag = s_trig_en | trig_held;

  word_t run_live;
  word_t qual_live;
  word_t run_pulse;
  logic  any_prot;

  assign any_prot = s_vprot | s_cprot;

  always_comb begin
    run_live = `RESET_WORD;
    run_live[`RUN_WTG_BIT]       = waiting_trigger_flag;
    run_live[`RUN_TRANS_ARM_BIT] = s_trans_arm;
    run_live[`RUN_CV_BIT]        = s_cv;
    run_live[`RUN_CC_BIT]        = s_cc;
    run_live[`RUN_SAMPLE_BIT]    = s_sample;
    run_live[`RUN_LIST_RUN_BIT]  = s_list_run;
    run_pulse = `RESET_WORD;
    run_pulse[`RUN_TRANS_DONE_BIT] = s_trans_done;
    run_pulse[`RUN_LIST_DONE_BIT]  = s_list_done;
  end

  always_comb begin
    qual_live = `RESET_WORD;
    qual_live[`QUAL_CUR_BIT]   = s_cc;
    qual_live[`QUAL_VOLT_BIT]  = s_cv;
    qual_live[`QUAL_THERM_BIT] = s_therm;
    qual_live[`QUAL_SLAVE_BIT] = s_slave;
    qual_live[`QUAL_VPROT_BIT] = s_vprot | (s_extref & any_prot);
    qual_live[`QUAL_CPROT_BIT] = s_cprot | (s_extref & any_prot);
    qual_live[`QUAL_SINK_BIT]  = s_sink;
  end

  // condition registers, registered for a stable readback
  word_t normal_run_condition;
  word_t signal_quality_condition;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      normal_run_condition     <= `RESET_WORD;
      signal_quality_condition <= `RESET_WORD;
    end else begin
      normal_run_condition     <= run_live & `RUN_COND_MASK;
      signal_quality_condition <= qual_live & `QUAL_COND_MASK;
    end
  end

  word_t run_enable;
  word_t quality_enable_mask;
  byte_t std_enable;
  byte_t srq_enable;

  function automatic logic addr_is(input reg_addr_t a, input reg_addr_t target);
    addr_is = (a == target);
  endfunction : addr_is

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      run_enable          <= `RESET_WORD;
      quality_enable_mask <= `RESET_WORD;
      std_enable          <= `RESET_BYTE;
      srq_enable          <= `RESET_BYTE;
    end else if (reg_wr) begin
      if (addr_is(reg_addr, `ADDR_RUN_ENABLE)) begin
        run_enable <= reg_wdata;
      end
      if (addr_is(reg_addr, `ADDR_QUAL_ENABLE)) begin
        quality_enable_mask <= reg_wdata;
      end
      if (addr_is(reg_addr, `ADDR_STD_ENABLE)) begin
        std_enable <= reg_wdata[7:0];
      end
      if (addr_is(reg_addr, `ADDR_SRQ_ENABLE)) begin
        srq_enable <= reg_wdata[7:0];
      end
    end
  end

  word_t run_events;
  word_t qual_events;
  byte_t std_events;

  // event bits 9 and 12 reach only the event path, as level pulses
  event_latch #(.W(16)) u_run_events (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .cond     (run_live & `RUN_COND_MASK),
    .pulse    (run_pulse),
    .rd_clear (reg_rd && addr_is(reg_addr, `ADDR_RUN_EVENT)),
    .events   (run_events)
  );

  event_latch #(.W(16)) u_qual_events (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .cond     (qual_live & `QUAL_COND_MASK),
    .pulse    (`RESET_WORD),
    .rd_clear (reg_rd && addr_is(reg_addr, `ADDR_QUAL_EVENT)),
    .events   (qual_events)
  );

  event_latch #(.W(8)) u_std_events (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .cond     (`RESET_BYTE),
    .pulse    (std_event_set),
    .rd_clear (reg_rd && addr_is(reg_addr, `ADDR_STD_EVENT)),
    .events   (std_events)
  );

  // status byte assembled from masked summaries plus the unmasked error queue and data-waiting bits
  byte_t next_status;
  logic  next_rqs;

  always_comb begin
    next_status = `RESET_BYTE;
    next_status[`STB_ERRQ_BIT] = s_errq;
    // error-free decode leaves s_errq low, so bit 3 reads zero unless an enabled quality event is latched
    next_status[`STB_QUAL_BIT] = (|(qual_events & quality_enable_mask)) | s_errq;
    next_status[`STB_MAV_BIT]  = s_mav;
    next_status[`STB_STD_BIT]  = |(std_events & std_enable);
    next_status[`STB_RUN_BIT]  = |(run_events & run_enable);
    next_rqs = |(next_status & srq_enable & ~(8'h01 << `STB_RQS_BIT));
    next_status[`STB_RQS_BIT] = next_rqs;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status_byte <= `RESET_BYTE;
      srq         <= 1'b0;
    end else begin
      status_byte <= next_status;
      srq         <= next_rqs;
    end
  end

  // read data one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata  <= `RESET_WORD;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `ADDR_RUN_COND:    reg_rdata <= normal_run_condition;
          `ADDR_RUN_EVENT:   reg_rdata <= run_events;
          `ADDR_RUN_ENABLE:  reg_rdata <= run_enable;
          `ADDR_QUAL_COND:   reg_rdata <= signal_quality_condition;
          `ADDR_QUAL_EVENT:  reg_rdata <= qual_events;
          `ADDR_QUAL_ENABLE: reg_rdata <= quality_enable_mask;
          `ADDR_STD_EVENT:   reg_rdata <= {8'h00, std_events};
          `ADDR_STD_ENABLE:  reg_rdata <= {8'h00, std_enable};
          `ADDR_SRQ_STATUS:  reg_rdata <= {8'h00, status_byte};
          `ADDR_SRQ_ENABLE:  reg_rdata <= {8'h00, srq_enable};
          default:           reg_rdata <= `RESET_WORD;
        endcase
      end
    end
  end
endmodule : status_reporting

// File: host_srq_model.sv
// Purpose: host controller side, serial-polls once per service request
// Assumes: srq is a registered level from the device
// Notes: counts requests and keeps the status byte seen at the latest one
`timescale 1ns/1ps
module host_srq_model
  import status_pkg::*;
(
  input  wire logic  mclk,
  input  wire logic  sys_rst,
  input  wire logic  srq,
  input  wire byte_t status_byte,
  output int         polls,
  output byte_t      last_poll
);
  logic srq_q;
  // edge, not level: a held request is one poll
  always_ff @(posedge mclk) begin
    srq_q <= srq;
    if (sys_rst) begin
      polls     <= 0;
      last_poll <= 8'h00;
    end else if (srq && !srq_q) begin
      polls     <= polls + 1;
      last_poll <= status_byte;
    end
  end
endmodule : host_srq_model

// File: status_reporting_assertions.sv
// Purpose: port checks of status_reporting
// Assumes: inputs held 5 cycles cover sync and register stages
// Notes: unused-bit masks written here on purpose, not taken from the map
`timescale 1ns/1ps
`include "status_map.svh"
module status_reporting_assertions
  import status_pkg::*;
(
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        sample_done,
  input wire logic        error_queue_nonempty,
  input wire logic        output_data_waiting,
  input wire reg_addr_t   reg_addr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [7:0]  status_byte,
  input wire logic        srq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_srq_follows: assert property (srq == status_byte[6])
    else $error("srq differs from status bit 6");
  a_data_waiting: assert property ($stable(output_data_waiting)[*5]
    |-> status_byte[4] == output_data_waiting)
    else $error("bit 4 does not track waiting data");
  a_queue_bits: assert property (error_queue_nonempty[*5] |-> status_byte[3])
    else $error("queue not reported in bit 3");
  a_summary_or: assert property (((status_byte & 8'hBF) == 8'h00)[*2]
    |-> !status_byte[6])
    else $error("bit 6 set with no other bit");
  a_run_unused: assert property (reg_rd && reg_addr == `ADDR_RUN_COND
    |=> (reg_rdata & ~16'h5F60) == 16'h0000)
    else $error("unused run bit reads one");
  a_run_event_only: assert property (reg_rd && reg_addr == `ADDR_RUN_COND
    |=> !reg_rdata[9] && !reg_rdata[12])
    else $error("event-only bit in run condition");
  a_qual_unused: assert property (reg_rd && reg_addr == `ADDR_QUAL_COND
    |=> (reg_rdata & ~16'h704B) == 16'h0000)
    else $error("unused quality bit reads one");
  a_sample_cond: assert property (sample_done[*5] ##0
    (reg_rd && reg_addr == `ADDR_RUN_COND) |=> reg_rdata[11])
    else $error("sample done not in bit 11");
endmodule : status_reporting_assertions
bind status_reporting status_reporting_assertions i_chk (.*);

// File: status_reporting_bench.sv
// Purpose: directed test of status_reporting through its register port
// Assumes: 100 MHz mclk, inputs driven at rising edges
// Notes: 6-cycle settle after each input change; the path needs 4
`timescale 1ns/1ps
`include "status_map.svh"
module status_reporting_bench
  import status_pkg::*;
;
  logic      mclk = 1'b0;
  logic      sys_rst = 1'b1;
  logic [17:0] st = '0;
  byte_t     std_set = 8'h00;
  reg_addr_t reg_addr = 4'h0;
  logic      reg_rd = 1'b0;
  logic      reg_wr = 1'b0;
  word_t     reg_wdata = 16'h0000;
  word_t     reg_rdata;
  logic      reg_rvalid;
  byte_t     status_byte;
  logic      srq;
  int        polls;
  int        error_cnt = 0;
  int        total_checks = 0;
  int        cycles = 0;
  word_t run_exp [18] = '{16'h0020, 16'h0000, 16'h0000, 16'h0040, 16'h0000, 16'h0100,
    16'h0400, 16'h0800, 16'h0000, 16'h4000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000};
  word_t qual_exp [18] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0002,
    16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0008, 16'h0040, 16'h1000, 16'h2000,
    16'h0000, 16'h4000, 16'h0000, 16'h0000};
  status_reporting i_dut (.mclk(mclk), .sys_rst(sys_rst), .trig_enabled(st[0]),
    .trig_external(st[1]), .trig_in(st[2]), .transient_armed(st[3]),
    .transient_done(st[4]), .volt_mode(st[5]), .curr_mode(st[6]), .sample_done(st[7]),
    .list_done(st[8]), .list_running(st[9]), .thermal_fault(st[10]),
    .slave_fault(st[11]), .volt_protect(st[12]), .curr_protect(st[13]),
    .ext_ref_enabled(st[14]), .sinking(st[15]), .error_queue_nonempty(st[16]),
    .output_data_waiting(st[17]), .std_event_set(std_set), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .status_byte(status_byte), .srq(srq));
  host_srq_model i_host (.mclk(mclk), .sys_rst(sys_rst), .srq(srq),
    .status_byte(status_byte), .polls(polls), .last_poll());
  task automatic end_of_test();
    $display("errors=%0d checks=%0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input word_t got, input word_t exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic put(input logic [17:0] v);
    @(posedge mclk);
    st <= v;
    repeat (6) @(posedge mclk);
  endtask : put
  task automatic wr(input reg_addr_t a, input word_t d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // data only counts when it comes with its valid pulse
  task automatic rd(input reg_addr_t a, input word_t exp);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    chk(reg_rvalid ? reg_rdata : 16'hDEAD, exp);
  endtask : rd
  initial begin
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 16; a++) rd(a[3:0], 16'h0000);
    for (int i = 0; i < 18; i++) begin
      put(18'h00001 << i);
      rd(`ADDR_RUN_COND, run_exp[i]);
      rd(`ADDR_QUAL_COND, qual_exp[i]);
      chk({8'h00, status_byte}, i == 16 ? 16'h000C : i == 17 ? 16'h0010 : 16'h0000);
    end
    put(18'h00000);
    rd(`ADDR_RUN_EVENT, 16'h5F60);
    rd(`ADDR_QUAL_EVENT, 16'h704B);
    rd(`ADDR_RUN_EVENT, 16'h0000);
    rd(`ADDR_QUAL_EVENT, 16'h0000);
    wr(`ADDR_RUN_ENABLE, 16'h0800);
    put(18'h00080);
    chk({8'h00, status_byte}, 16'h0080);
    rd(`ADDR_RUN_EVENT, 16'h0800);
    // cleared events reach the status byte one edge after the read answer
    repeat (2) @(posedge mclk);
    chk({8'h00, status_byte}, 16'h0000);
    wr(`ADDR_QUAL_ENABLE, 16'h0001);
    put(18'h00040);
    chk({8'h00, status_byte}, 16'h0008);
    wr(`ADDR_SRQ_ENABLE, 16'h0008);
    repeat (3) @(posedge mclk);
    rd(`ADDR_SRQ_STATUS, 16'h0048);
    chk({15'h0000, srq}, 16'h0001);
    chk(polls[15:0], 16'h0001);
    rd(`ADDR_QUAL_EVENT, 16'h0001);
    repeat (2) @(posedge mclk);
    chk({7'h00, srq, status_byte}, 16'h0000);
    put(18'h00003);
    rd(`ADDR_RUN_COND, 16'h0020);
    put(18'h00002);
    rd(`ADDR_RUN_COND, 16'h0020);
    put(18'h00006);
    rd(`ADDR_RUN_COND, 16'h0000);
    put(18'h05000);
    rd(`ADDR_QUAL_COND, 16'h3000);
    @(posedge mclk);
    std_set <= 8'h01;
    @(posedge mclk);
    std_set <= 8'h00;
    rd(`ADDR_STD_EVENT, 16'h0001);
    rd(`ADDR_STD_EVENT, 16'h0000);
    wr(`ADDR_STD_ENABLE, 16'h0001);
    // a new event in the very cycle of the clearing read must survive it
    @(posedge mclk);
    std_set  <= 8'h01;
    reg_rd   <= 1'b1;
    reg_addr <= `ADDR_STD_EVENT;
    @(posedge mclk);
    std_set <= 8'h00;
    reg_rd  <= 1'b0;
    @(posedge mclk);
    chk(reg_rvalid ? reg_rdata : 16'hDEAD, 16'h0000);
    repeat (2) @(posedge mclk);
    chk({8'h00, status_byte}, 16'h0020);
    rd(`ADDR_STD_EVENT, 16'h0001);
    end_of_test();
  end
endmodule : status_reporting_bench
